// >>> ads_pkg.sv
// constants, types and register map of the a/d result store and scan control
// assumes an ahb-lite bus of 32-bit data and a 20 MHz hclk
package ads_pkg;
    // register byte offsets
    localparam logic [6:0] ADS_OFF_CTRL = 7'h00;
    localparam logic [6:0] ADS_OFF_SEL = 7'h04;
    localparam logic [6:0] ADS_OFF_STAT = 7'h08;
    localparam logic [6:0] ADS_OFF_RES0 = 7'h10; // channels 0..7 follow
    localparam logic [6:0] ADS_OFF_DUP0 = 7'h30; // three duplication words
    localparam logic [6:0] ADS_OFF_REF = 7'h3c;
    localparam logic [6:0] ADS_OFF_DIAG = 7'h40;
    // control word fields
    localparam int ADS_CTRL_START = 0;
    localparam int ADS_CTRL_STOP = 1;
    localparam int ADS_CTRL_MODE = 2; // two bits
    localparam int ADS_CTRL_DBL = 4;
    localparam int ADS_CTRL_DCH = 5; // three bits
    localparam int ADS_CTRL_EXT = 8;
    localparam int ADS_CTRL_ADD = 9; // two bits
    localparam int ADS_CTRL_TRG = 11;
    // scan modes
    localparam logic [1:0] ADS_MODE_SINGLE = 2'h0;
    localparam logic [1:0] ADS_MODE_CONT = 2'h1;
    localparam logic [1:0] ADS_MODE_GROUP = 2'h2;
    // addition modes and their last sample index
    localparam logic [1:0] ADS_ADD_OFF = 2'h0;
    localparam logic [1:0] ADS_ADD_X4 = 2'h1;
    localparam logic [3:0] ADS_ADD_LAST4 = 4'h3;
    localparam logic [3:0] ADS_ADD_LAST16 = 4'hf;
    // conversion targets: 0..7 analog, then reference, then self-diagnosis
    localparam int ADS_NCH = 8;
    localparam int ADS_NDUP = 3;
    localparam logic [3:0] ADS_IDX_REF = 4'h8;
    localparam logic [3:0] ADS_IDX_DIAG = 4'h9;
    localparam int ADS_NIDX = 10;
    // start source codes
    localparam logic [1:0] ADS_SRC_SW = 2'h0;
    // reset values
    localparam logic [15:0] ADS_RES_RST = 16'h0000;
    localparam logic [9:0] ADS_SEL_RST = 10'h000;

    typedef enum logic [0:0] {
        ADS_ST_IDLE,
        ADS_ST_WAIT
    } ads_state_e;

    typedef struct packed {
        ads_state_e st;
        logic [1:0] mode;
        logic dbl_en;
        logic [2:0] dbl_ch;
        logic ext_en;
        logic [1:0] add_md;
        logic trig_en;
        logic [9:0] sel;
        logic [3:0] idx;
        logic [15:0] acc;
        logic [3:0] acnt;
        logic dbl_sec;
        logic [1:0] src;
        logic [ADS_NCH-1:0][15:0] res;
        logic [ADS_NDUP-1:0][15:0] dup;
        logic [15:0] refr;
        logic [15:0] diag;
        logic [6:0] addr;
        logic wr;
        logic dph;
        logic [31:0] rdata;
        logic conv_start;
        logic [3:0] conv_sel;
    } ads_regs_s;
endpackage

// >>> ads_core.sv
// a/d converter digital control: result store, duplication, addition, scan
// assumes a conversion engine that takes conv_start/conv_sel and answers
// with a one-cycle conv_done carrying a 12-bit result; triggers are pulses
`timescale 1ns/100ps
`default_nettype none
module ads_core import ads_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [1:0] trig_req,
    input wire logic conv_done,
    input wire logic [11:0] conv_data,
    output logic conv_start,
    output logic [3:0] conv_sel,
    output logic busy
);
    ads_regs_s q, d;
    logic fin; // last sample of a target lands this cycle
    logic [15:0] sum;
    logic dbl_act;
    logic [4:0] nxt;

    // first selected target at or after from; bit 4 says one was found
    function automatic logic [4:0] next_sel(input logic [9:0] sel,
                                            input logic [4:0] from);
        logic [4:0] r;
        r = 5'h00;
        for (int i = ADS_NIDX - 1; i >= 0; i--) begin
            if (sel[i] && (5'(i) >= from)) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // register read mux, answered from the address phase
    function automatic logic [31:0] rd_word(input ads_regs_s s,
                                            input logic [6:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == ADS_OFF_CTRL) begin
            w = {20'h00000, s.trig_en, s.add_md, s.ext_en, s.dbl_ch,
                 s.dbl_en, s.mode, 2'h0};
        end else if (a == ADS_OFF_SEL) begin
            w = {22'h000000, s.sel};
        end else if (a == ADS_OFF_STAT) begin
            w = {23'h000000, s.dbl_sec, s.idx, 3'h0,
                 s.st == ADS_ST_WAIT};
        end else if (a >= ADS_OFF_RES0 && a < ADS_OFF_DUP0) begin
            // channel words start at 0x10, so bit 4 of the offset is biased
            w = {16'h0000, s.res[a[4:2] ^ 3'h4]};
        end else if (a >= ADS_OFF_DUP0 && a < ADS_OFF_REF) begin
            w = {16'h0000, s.dup[2'(a[3:2])]};
        end else if (a == ADS_OFF_REF) begin
            w = {16'h0000, s.refr};
        end else if (a == ADS_OFF_DIAG) begin
            w = {16'h0000, s.diag};
        end
        return w;
    endfunction

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign conv_start = q.conv_start;
    assign conv_sel = q.conv_sel;
    assign busy = (q.st == ADS_ST_WAIT);

    // double trigger is ignored in continuous scan
    assign dbl_act = q.dbl_en && (q.mode != ADS_MODE_CONT);
    assign sum = q.acc + {4'h0, conv_data};
    assign fin = (q.st == ADS_ST_WAIT) && conv_done &&
                 ((q.add_md == ADS_ADD_OFF) ||
                  (q.acnt == ((q.add_md == ADS_ADD_X4) ?
                              ADS_ADD_LAST4 : ADS_ADD_LAST16)));
    assign nxt = next_sel(q.sel, 5'(q.idx) + 5'h01);

    // next state of the whole block
    always_comb begin
        logic start;
        logic [4:0] first;
        logic [31:0] wd;
        d = q;
        start = 1'b0;
        first = next_sel(q.sel, 5'h00);
        wd = hwdata;
        d.conv_start = 1'b0;
        // bus address phase
        d.dph = hsel && htrans[1] && hready;
        if (hsel && htrans[1] && hready) begin
            d.addr = haddr[6:0];
            d.wr = hwrite;
            d.rdata = rd_word(q, haddr[6:0]);
        end
        // bus data phase writes
        if (q.dph && q.wr && q.addr == ADS_OFF_SEL) begin
            d.sel = wd[9:0];
        end
        if (q.dph && q.wr && q.addr == ADS_OFF_CTRL) begin
            d.mode = wd[ADS_CTRL_MODE +: 2];
            d.dbl_en = wd[ADS_CTRL_DBL];
            d.dbl_ch = wd[ADS_CTRL_DCH +: 3];
            d.ext_en = wd[ADS_CTRL_EXT];
            d.add_md = wd[ADS_CTRL_ADD +: 2];
            d.trig_en = wd[ADS_CTRL_TRG];
            d.dbl_sec = 1'b0; // a new setup restarts the pair
            if (wd[ADS_CTRL_STOP]) begin
                d.st = ADS_ST_IDLE; // abort; results already stored stay
                d.acc = 16'h0000;
                d.acnt = 4'h0;
            end else if (wd[ADS_CTRL_START] && q.st == ADS_ST_IDLE) begin
                start = 1'b1;
                d.src = ADS_SRC_SW;
            end
        end
        // hardware triggers only when idle; type 1 wins over type 0
        if (!start && q.st == ADS_ST_IDLE && q.trig_en && |trig_req &&
            !(q.dph && q.wr && q.addr == ADS_OFF_CTRL)) begin
            start = 1'b1;
            d.src = trig_req[1] ? 2'h2 : 2'h1;
        end
        if (start) begin
            if (d.dbl_en && d.mode != ADS_MODE_CONT) begin
                d.idx = {1'b0, d.dbl_ch};
                d.st = ADS_ST_WAIT;
                d.conv_start = 1'b1;
            end else if (first[4]) begin
                d.idx = first[3:0];
                d.st = ADS_ST_WAIT;
                d.conv_start = 1'b1;
            end
            d.conv_sel = d.idx;
            d.acc = 16'h0000;
            d.acnt = 4'h0;
        end
        // conversion answer
        if (q.st == ADS_ST_WAIT && conv_done && !fin) begin
            d.acc = sum;
            d.acnt = q.acnt + 4'h1;
            d.conv_start = 1'b1; // same target again
        end
        if (fin) begin
            d.acc = 16'h0000;
            d.acnt = 4'h0;
            // only the addressed register changes
            if (dbl_act && q.idx == {1'b0, q.dbl_ch}) begin
                if (q.ext_en && q.src != ADS_SRC_SW) begin
                    d.dup[q.src] = sum;
                end else if (q.dbl_sec) begin
                    d.dup[0] = sum;
                    d.dbl_sec = 1'b0;
                end else begin
                    d.res[q.idx[2:0]] = sum;
                    d.dbl_sec = 1'b1;
                end
            end else if (q.idx == ADS_IDX_REF) begin
                d.refr = sum;
            end else if (q.idx == ADS_IDX_DIAG) begin
                d.diag = sum;
            end else begin
                d.res[q.idx[2:0]] = sum;
            end
            // advance the scan
            if (dbl_act) begin
                d.st = ADS_ST_IDLE;
            end else if (nxt[4]) begin
                d.idx = nxt[3:0];
                d.conv_start = 1'b1;
            end else if (q.mode == ADS_MODE_CONT && first[4]) begin
                d.idx = first[3:0];
                d.conv_start = 1'b1;
            end else begin
                d.st = ADS_ST_IDLE;
            end
            d.conv_sel = d.idx;
        end
        // a stop written in the same cycle overrides a relaunch
        if (q.dph && q.wr && q.addr == ADS_OFF_CTRL &&
            wd[ADS_CTRL_STOP]) begin
            d.st = ADS_ST_IDLE;
            d.conv_start = 1'b0;
        end
    end

    // single register stage for all state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '{st: ADS_ST_IDLE, mode: ADS_MODE_SINGLE, dbl_en: 1'b0,
                   dbl_ch: 3'h0, ext_en: 1'b0, add_md: ADS_ADD_OFF,
                   trig_en: 1'b0, sel: ADS_SEL_RST, idx: 4'h0,
                   acc: 16'h0000, acnt: 4'h0, dbl_sec: 1'b0,
                   src: ADS_SRC_SW, res: '{default: ADS_RES_RST},
                   dup: '{default: ADS_RES_RST}, refr: ADS_RES_RST,
                   diag: ADS_RES_RST, addr: 7'h00, wr: 1'b0, dph: 1'b0,
                   rdata: 32'h0000_0000, conv_start: 1'b0,
                   conv_sel: 4'h0};
        end else begin
            q <= d;
        end
    end

    // checks on the stored results and the scan
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_start_one: assert property (
        conv_start |=> !conv_start until conv_done)
        else $error("conversion requested twice before an answer");
    chk_wait_busy: assert property (
        conv_start |-> busy)
        else $error("conversion started while idle");
    chk_hold_res: assert property (
        !fin |=> $stable(q.res) && $stable(q.dup) &&
                 $stable(q.refr) && $stable(q.diag))
        else $error("result changed with no conversion landing");
    chk_plain_width: assert property (
        fin && q.add_md == ADS_ADD_OFF && q.idx < ADS_IDX_REF &&
        !dbl_act |=> q.res[$past(q.idx[2:0])] == {4'h0, $past(conv_data)})
        else $error("plain result not stored as twelve bits");
    chk_add_width: assert property (
        fin && q.add_md == ADS_ADD_X4 |-> sum < 16'h4000)
        else $error("four-sample sum wider than fourteen bits");
    chk_ref_store: assert property (
        fin && q.idx == ADS_IDX_REF && q.add_md == ADS_ADD_OFF
        |=> q.refr == {4'h0, $past(conv_data)})
        else $error("reference result not in its register");
    chk_diag_store: assert property (
        fin && q.idx == ADS_IDX_DIAG && q.add_md == ADS_ADD_OFF
        |=> q.diag == {4'h0, $past(conv_data)})
        else $error("diagnosis result not in its register");
    chk_dbl_mode: assert property (
        fin && q.mode == ADS_MODE_CONT |=> $stable(q.dup))
        else $error("duplication written in continuous scan");
    chk_dbl_pair: assert property (
        fin && dbl_act && q.dbl_sec && q.src == ADS_SRC_SW
        |=> q.dup[0] == $past(sum) && !busy)
        else $error("second result missed the duplicate");
    chk_ext_route: assert property (
        fin && dbl_act && q.ext_en && q.src == 2'h2
        |=> q.dup[2] == $past(sum))
        else $error("extended result not in trigger register");
    chk_single_end: assert property (
        fin && q.mode == ADS_MODE_SINGLE && !nxt[4] && !conv_start
        && !(q.dph && q.wr) |=> !busy)
        else $error("single scan did not stop after last target");
    chk_cont_loop: assert property (
        fin && q.mode == ADS_MODE_CONT && q.sel != 10'h000 &&
        !(q.dph && q.wr) |=> conv_start && busy)
        else $error("continuous scan did not restart");

    cov_cont_wrap: cover property (
        fin && q.mode == ADS_MODE_CONT && !nxt[4]);
    cov_dbl_second: cover property (fin && dbl_act && q.dbl_sec);
    cov_ext_trig: cover property (fin && dbl_act && q.ext_en &&
                                  q.src != ADS_SRC_SW);
    cov_add16: cover property (fin && q.add_md == 2'h2);
endmodule
`default_nettype wire

// >>> ads_conv_model.sv
// behavioural conversion engine facing ads_core
// assumes the bench sets base and lat; result is base plus target index
`timescale 1ns/100ps
`default_nettype none
module ads_conv_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic conv_start,
    input wire logic [3:0] conv_sel,
    input wire logic [11:0] base,
    input wire logic [4:0] lat,
    output logic conv_done,
    output logic [11:0] conv_data
);
    logic [4:0] cnt_q;
    logic [3:0] tgt_q;
    logic [11:0] val_q;

    // one answer per start, lat cycles later (lat of 1 is prompt)
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 5'h00;
            tgt_q <= 4'h0;
            val_q <= 12'h000;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (conv_start) begin
                cnt_q <= lat;
                tgt_q <= conv_sel;
            end else if (cnt_q == 5'h01) begin
                conv_done <= 1'b1;
                val_q <= base + 12'(tgt_q);
                cnt_q <= 5'h00;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end

    // data outside the done pulse is inverted so stale reads show up
    assign conv_data = conv_done ? val_q : ~val_q;
endmodule
`default_nettype wire

// >>> ads_core_test.sv
// self-checking bench of the a/d result store and scan control
// assumes ads_core as ahb-lite slave and ads_conv_model as converter
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
    $display("Error %s exp %h got %h", nm, e, s); end end
module ads_core_test;
    import ads_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic conv_done, conv_start, busy;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, trig_req;
    logic [2:0] hsize;
    logic [11:0] conv_data, base;
    logic [3:0] conv_sel;
    logic [4:0] lat;
    int fails = 0;
    int n_checks = 0;
    int n_conv = 0;

    ads_core u_ads_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .trig_req(trig_req),
        .conv_done(conv_done), .conv_data(conv_data),
        .conv_start(conv_start), .conv_sel(conv_sel), .busy(busy));
    ads_conv_model u_ads_conv_model (.hclk(hclk), .hresetn(hresetn),
        .conv_start(conv_start), .conv_sel(conv_sel), .base(base),
        .lat(lat), .conv_done(conv_done), .conv_data(conv_data));

    // conversions launched, to prove each target is taken once
    always @(posedge hclk) begin
        if (conv_start === 1'b1) begin
            n_conv <= n_conv + 1;
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic over(input int n);
        if (n >= 400) begin
            fails++;
            $display("Error wait exp done got hang");
            test_done();
        end
    endtask

    // one single transfer; called right after a rising edge
    task automatic xfer(input logic w, input logic [6:0] a,
                        input logic [31:0] d);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {25'h0, a};
        hwrite <= w;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 400);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 400);
        over(n);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic chk(input string nm, input logic [6:0] a,
                       input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (busy !== 1'b0 && n < 400);
        over(n);
    endtask

    task automatic wait_conv(input int k);
        int n, t;
        n = 0;
        t = n_conv + k;
        do begin
            @(posedge hclk);
            n++;
        end while (n_conv < t && n < 400);
        over(n);
    endtask

    task automatic pulse(input logic [1:0] v);
        trig_req <= v;
        @(posedge hclk);
        trig_req <= 2'h0;
        wait_idle();
    endtask

    task automatic t_reset();
        chk("res0", ADS_OFF_RES0, 32'h0);
        chk("dup2", ADS_OFF_DUP0 + 7'h08, 32'h0);
        chk("unmapped", 7'h7c, 32'h0);
    endtask

    // near full-scale values, channels 0 and 7 plus reference and diagnosis
    task automatic t_single();
        int t;
        base <= 12'hff0;
        wr(ADS_OFF_SEL, 32'h381);
        t = n_conv;
        wr(ADS_OFF_CTRL, 32'h1);
        wait_idle();
        `CHK("convs", t + 4, n_conv)
        chk("res0", ADS_OFF_RES0, 32'hff0);
        chk("res7", ADS_OFF_RES0 + 7'h1c, 32'hff7);
        chk("res1", ADS_OFF_RES0 + 7'h04, 32'h0);
        chk("ref", ADS_OFF_REF, 32'hff8);
        chk("diag", ADS_OFF_DIAG, 32'hff9);
        base <= 12'h123;
        wr(ADS_OFF_SEL, 32'h1);
        wr(ADS_OFF_CTRL, 32'h1);
        wait_idle();
        chk("res0", ADS_OFF_RES0, 32'h123);
        chk("res7", ADS_OFF_RES0 + 7'h1c, 32'hff7);
        chk("ref", ADS_OFF_REF, 32'hff8);
    endtask

    // sums of the largest code overflow twelve bits on purpose
    task automatic t_add();
        base <= 12'hffe;
        wr(ADS_OFF_SEL, 32'h2);
        wr(ADS_OFF_CTRL, 32'h201);
        wait_idle();
        chk("sum4", ADS_OFF_RES0 + 7'h04, 32'h3ffc);
        wr(ADS_OFF_CTRL, 32'h401);
        wait_idle();
        chk("sum16", ADS_OFF_RES0 + 7'h04, 32'hfff0);
    endtask

    // group mode, double on channel 3, then extended per trigger type
    task automatic t_double();
        lat <= 5'd4;
        wr(ADS_OFF_CTRL, 32'h878);
        base <= 12'h200;
        pulse(2'h1);
        base <= 12'h300;
        pulse(2'h2);
        chk("res3", ADS_OFF_RES0 + 7'h0c, 32'h203);
        chk("dup0", ADS_OFF_DUP0, 32'h303);
        wr(ADS_OFF_CTRL, 32'h978);
        base <= 12'h400;
        pulse(2'h1);
        base <= 12'h500;
        pulse(2'h2);
        chk("dup1", ADS_OFF_DUP0 + 7'h04, 32'h403);
        chk("dup2", ADS_OFF_DUP0 + 7'h08, 32'h503);
        chk("dup0", ADS_OFF_DUP0, 32'h303);
    endtask

    // continuous with the double bit set: double must be ignored
    task automatic t_cont();
        lat <= 5'd3;
        base <= 12'h600;
        wr(ADS_OFF_SEL, 32'h4);
        wr(ADS_OFF_CTRL, 32'h15);
        wait_conv(3);
        chk("res2", ADS_OFF_RES0 + 7'h08, 32'h602);
        base <= 12'h700;
        wait_conv(2);
        `CHK("busy", 1'b1, busy)
        chk("res2", ADS_OFF_RES0 + 7'h08, 32'h702);
        wr(ADS_OFF_CTRL, 32'h2);
        wait_idle();
        chk("dup0", ADS_OFF_DUP0, 32'h303);
        chk("res3", ADS_OFF_RES0 + 7'h0c, 32'h203);
    endtask

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // reset for four cycles, then every scenario in turn
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        trig_req = 2'h0;
        base = 12'h000;
        lat = 5'd1;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_single();
        t_add();
        t_double();
        t_cont();
        test_done();
    end
endmodule
`default_nettype wire
